// ### design/cbs_sideband.v
// processor-side system bus sequencer and sideband pin logic
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "cbs_defines.vh"
module cbs_sideband #(
    parameter CACHE_LINES  = 16,
    parameter LINE_W       = 4,
    parameter ADDR_W       = 33,
    parameter RESET_VECTOR = 32'hFFFFFFF0
) (
    // clock and reset
    input  wire              ref_clk_i,
    input  wire              rst_n_i,
    // apb slave
    input  wire              psel_i,
    input  wire              penable_i,
    input  wire              pwrite_i,
    input  wire [7:0]        paddr_i,
    input  wire [31:0]       pwdata_i,
    output reg  [31:0]       prdata_o,
    output wire              pready_o,
    output wire              pslverr_o,
    // system bus, same clock
    output reg  [4:0]        req_cmd_o,
    output reg  [ADDR_W-1:0] addr_o,
    output reg               addr_strobe_o,
    output reg  [63:0]       data_o,
    output reg  [7:0]        data_ecc_lines_o,
    output reg               data_oe_o,
    output reg               data_valid_strobe_o,
    output reg               atomic_seq_o,
    output reg               snoop_match_o,
    output reg               snoop_dirty_match_o,
    input  wire [63:0]       data_i,
    input  wire [7:0]        data_ecc_lines_i,
    input  wire              data_valid_strobe_i,
    input  wire              target_ready_i,
    input  wire              snoop_match_i,
    input  wire              snoop_dirty_match_i,
    input  wire              priority_agent_request_i,
    input  wire              bus_reinit_i,
    // asynchronous sideband pins
    input  wire              purge_req_i,
    input  wire              warm_restart_i,
    input  wire [1:0]        local_irq_pins_i,
    input  wire              numeric_error_override_i,
    input  wire              supply_stable_in_i,
    input  wire              irq_bus_data0_i,
    input  wire              ecc_strap_i,
    // sideband outputs
    output reg               fpu_fault_out_o,
    output reg               internal_fault_out_o,
    output reg  [1:0]        local_irq_o,
    // core and cache side
    input  wire              fp_error_i,
    input  wire              fp_instr_i,
    input  wire              internal_error_i,
    input  wire              instr_done_i,
    input  wire              handler_return_i,
    input  wire              cache_line_dirty_i,
    output reg               fp_stall_o,
    output reg  [LINE_W-1:0] cache_line_o,
    output reg               cache_writeback_o,
    output reg               cache_invalidate_o,
    output wire              cache_alloc_en_o,
    output reg               int_reset_o,
    output reg               exec_start_o,
    output reg  [31:0]       reset_vector_o,
    output reg               bist_run_o,
    output reg               irq_take_o,
    output reg               nmi_take_o,
    output reg  [7:0]        irq_vector_o
);

// ****************************************
// functions
// ****************************************
function [7:0] ecc_of;
    input [63:0] d;
    integer k;
    begin
        for (k = 0; k < 8; k = k + 1) begin
            ecc_of[k] = ^d[8*k +: 8];
        end
    end
endfunction

// ****************************************
// input synchronisers and glitch filter
// ****************************************
wire [7:0] async_in = {ecc_strap_i, irq_bus_data0_i, supply_stable_in_i, numeric_error_override_i,
                       local_irq_pins_i, warm_restart_i, purge_req_i};
reg  [7:0] s1_reg;
reg  [7:0] s2_reg;
reg  [7:0] s3_reg;
reg  [7:0] filt_reg;
reg  [7:0] filt_d_reg;

always @(posedge ref_clk_i) begin
    s1_reg <= async_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
end

always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        filt_reg   <= 8'h00;
        filt_d_reg <= 8'h00;
    end else begin
        // a level is taken only after two agreeing samples
        filt_reg   <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
        filt_d_reg <= filt_reg;
    end
end

wire [7:0] rise = filt_reg & ~filt_d_reg;

// ****************************************
// power-on configuration
// ****************************************
reg cfg_done_reg;
reg ecc_en_reg;
reg purge_cfg_reg;
reg bist_cfg_reg;
reg ctl_dis_reg;

always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        cfg_done_reg  <= 1'b0;
        ecc_en_reg    <= 1'b0;
        purge_cfg_reg <= 1'b0;
        bist_cfg_reg  <= 1'b0;
        ctl_dis_reg   <= 1'b0;
        bist_run_o    <= 1'b0;
    end else begin
        bist_run_o <= 1'b0;
        if (!cfg_done_reg) begin
            cfg_done_reg  <= 1'b1;
            ecc_en_reg    <= s2_reg[`CBS_IN_ECCSTRAP];
            purge_cfg_reg <= s2_reg[`CBS_IN_PURGE];
            bist_cfg_reg  <= s2_reg[`CBS_IN_WARM];
            bist_run_o    <= s2_reg[`CBS_IN_WARM];
            ctl_dis_reg   <= ~s2_reg[`CBS_IN_IRQD0];
        end
    end
end

// ****************************************
// apb registers
// ****************************************
reg  [7:0]        ctrl_reg;
reg  [10:0]       cmd_reg;
reg  [ADDR_W-1:0] addr_reg;
reg  [63:0]       wdata_reg;
reg  [63:0]       rdata_reg;
reg               sw_pend_reg;
reg  [1:0]        state_reg;
reg               in_nmi_reg;
reg               nmi_pend_reg;
reg               ifault_reg;
reg               fp_err_reg;
reg               ecc_err_reg;
reg               flushing_reg;
reg               irq_wait_reg;
reg               stall_seen_reg;

wire setup    = psel_i & ~penable_i;
wire access   = psel_i & penable_i;
wire mapped   = (paddr_i[1:0] == 2'h0) && (paddr_i <= `CBS_REG_CONFIG);
wire cmd_hit  = (paddr_i == `CBS_REG_CMD);
wire cmd_busy = sw_pend_reg | (state_reg != `CBS_ST_IDLE);
wire wr_ok    = access & pwrite_i & mapped & ~(cmd_hit & cmd_busy);
wire ctl_wr   = wr_ok & (paddr_i == `CBS_REG_CTRL);
wire cmd_wr   = wr_ok & cmd_hit;

assign pready_o  = 1'b1;
assign pslverr_o = access & (~mapped | (pwrite_i & cmd_hit & cmd_busy));

wire [31:0] status_w = {20'h0, irq_wait_reg, fp_stall_o, stall_seen_reg, filt_reg[`CBS_IN_SUPPLY],
                        nmi_pend_reg, in_nmi_reg, ecc_err_reg, fp_err_reg, ifault_reg, flushing_reg,
                        atomic_seq_o, cmd_busy};

always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        ctrl_reg  <= `CBS_CTRL_RST;
        cmd_reg   <= 11'h000;
        addr_reg  <= {ADDR_W{1'b0}};
        wdata_reg <= 64'h0;
        prdata_o  <= 32'h0;
    end else begin
        ctrl_reg[7:4] <= 4'h0;
        if (ctl_wr) begin
            ctrl_reg <= pwdata_i[7:0];
        end
        if (cmd_wr) begin
            cmd_reg <= pwdata_i[10:0];
        end
        if (wr_ok && paddr_i == `CBS_REG_ADDR) begin
            addr_reg <= {{(ADDR_W-32){1'b0}}, pwdata_i};
        end
        if (wr_ok && paddr_i == `CBS_REG_WDLO) begin
            wdata_reg[31:0] <= pwdata_i;
        end
        if (wr_ok && paddr_i == `CBS_REG_WDHI) begin
            wdata_reg[63:32] <= pwdata_i;
        end
        if (setup && !pwrite_i) begin
            case (paddr_i)
                `CBS_REG_CTRL:   prdata_o <= {28'h0, ctrl_reg[3:0]};
                `CBS_REG_CMD:    prdata_o <= {21'h0, cmd_reg};
                `CBS_REG_ADDR:   prdata_o <= addr_reg[31:0];
                `CBS_REG_WDLO:   prdata_o <= wdata_reg[31:0];
                `CBS_REG_WDHI:   prdata_o <= wdata_reg[63:32];
                `CBS_REG_STATUS: prdata_o <= status_w;
                `CBS_REG_RDLO:   prdata_o <= rdata_reg[31:0];
                `CBS_REG_RDHI:   prdata_o <= rdata_reg[63:32];
                `CBS_REG_CONFIG: prdata_o <= {28'h0, ctl_dis_reg, bist_cfg_reg, purge_cfg_reg, ecc_en_reg};
                default:         prdata_o <= 32'h0;
            endcase
        end
    end
end

// ****************************************
// bus transaction sequencer
// ****************************************
reg        shut_pend_reg;
reg        fack_pend_reg;
reg        iack_pend_reg;
reg        cur_data_reg;
reg        cur_end_reg;
reg [63:0] cur_wd_reg;

wire can_issue = cfg_done_reg & filt_reg[`CBS_IN_SUPPLY] & (~priority_agent_request_i | atomic_seq_o);
wire any_pend  = shut_pend_reg | fack_pend_reg | iack_pend_reg | sw_pend_reg;
wire go        = (state_reg == `CBS_ST_IDLE) & can_issue & any_pend;
wire take_shut = go & shut_pend_reg;
wire take_fack = go & ~shut_pend_reg & fack_pend_reg;
wire take_iack = go & ~shut_pend_reg & ~fack_pend_reg & iack_pend_reg;
wire take_sw   = go & ~shut_pend_reg & ~fack_pend_reg & ~iack_pend_reg;
wire flush_fin;
wire irq_take;

always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        state_reg           <= `CBS_ST_IDLE;
        req_cmd_o           <= 5'h00;
        addr_o              <= {ADDR_W{1'b0}};
        addr_strobe_o       <= 1'b0;
        data_o              <= 64'h0;
        data_ecc_lines_o    <= 8'h00;
        data_oe_o           <= 1'b0;
        data_valid_strobe_o <= 1'b0;
        atomic_seq_o        <= 1'b0;
        cur_data_reg        <= 1'b0;
        cur_end_reg         <= 1'b1;
        cur_wd_reg          <= 64'h0;
    end else begin
        case (state_reg)
            `CBS_ST_IDLE: begin
                if (go) begin
                    state_reg     <= `CBS_ST_REQ;
                    addr_strobe_o <= 1'b1;
                    addr_o        <= take_sw ? addr_reg : {ADDR_W{1'b0}};
                    req_cmd_o     <= take_shut ? `CBS_CMD_SHUTDOWN :
                                     take_fack ? `CBS_CMD_FLUSH_ACK :
                                     take_iack ? `CBS_CMD_IRQ_ACK : cmd_reg[4:0];
                    cur_data_reg  <= take_sw & cmd_reg[`CBS_CMD_DATA];
                    cur_wd_reg    <= wdata_reg;
                    cur_end_reg   <= ~(take_sw & cmd_reg[`CBS_CMD_LOCK]) | cmd_reg[`CBS_CMD_LAST];
                    if (take_sw && cmd_reg[`CBS_CMD_LOCK]) begin
                        atomic_seq_o <= 1'b1;
                    end
                end
            end
            `CBS_ST_REQ: begin
                addr_strobe_o <= 1'b0;
                req_cmd_o     <= 5'h00;
                if (cur_data_reg) begin
                    state_reg <= `CBS_ST_DATA;
                end else begin
                    state_reg <= `CBS_ST_IDLE;
                    if (cur_end_reg) begin
                        atomic_seq_o <= 1'b0;
                    end
                end
            end
            `CBS_ST_DATA: begin
                if (data_valid_strobe_o) begin
                    data_valid_strobe_o <= 1'b0;
                    data_oe_o           <= 1'b0;
                    state_reg           <= `CBS_ST_IDLE;
                    if (cur_end_reg) begin
                        atomic_seq_o <= 1'b0;
                    end
                end else if (target_ready_i) begin
                    // idle clocks are inserted while the target is not ready
                    data_valid_strobe_o <= 1'b1;
                    data_oe_o           <= 1'b1;
                    data_o              <= cur_wd_reg;
                    data_ecc_lines_o    <= ecc_of(cur_wd_reg);
                end
            end
            default: state_reg <= `CBS_ST_IDLE;
        endcase
    end
end

// ****************************************
// pending transactions and receive side
// ****************************************
always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        sw_pend_reg    <= 1'b0;
        shut_pend_reg  <= 1'b0;
        fack_pend_reg  <= 1'b0;
        iack_pend_reg  <= 1'b0;
        rdata_reg      <= 64'h0;
        ecc_err_reg    <= 1'b0;
        stall_seen_reg <= 1'b0;
    end else begin
        sw_pend_reg    <= cmd_wr | (sw_pend_reg & ~take_sw);
        shut_pend_reg  <= internal_error_i | (shut_pend_reg & ~take_shut);
        fack_pend_reg  <= flush_fin | (fack_pend_reg & ~take_fack);
        iack_pend_reg  <= irq_take | (iack_pend_reg & ~take_iack);
        stall_seen_reg <= snoop_match_i & snoop_dirty_match_i;
        if (data_valid_strobe_i && !data_oe_o) begin
            rdata_reg <= data_i;
        end
        // a new error wins over a clear in the same cycle
        ecc_err_reg <= (data_valid_strobe_i & ~data_oe_o & ecc_en_reg & (ecc_of(data_i) != data_ecc_lines_i)) |
                       (ecc_err_reg & ~ctrl_reg[`CBS_CTRL_ECCCLR]);
    end
end

// ****************************************
// cache purge
// ****************************************
// the walk wraps at the index width, so the line count must not exceed it
localparam [LINE_W-1:0] LAST_LINE = CACHE_LINES[LINE_W-1:0] - 1'b1;

reg [LINE_W-1:0] walk_reg;

assign cache_alloc_en_o = cfg_done_reg & ~filt_reg[`CBS_IN_PURGE];
assign flush_fin        = flushing_reg & (walk_reg == LAST_LINE);

always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        flushing_reg       <= 1'b0;
        walk_reg           <= {LINE_W{1'b0}};
        cache_line_o       <= {LINE_W{1'b0}};
        cache_writeback_o  <= 1'b0;
        cache_invalidate_o <= 1'b0;
    end else begin
        cache_writeback_o  <= flushing_reg & cache_line_dirty_i;
        cache_invalidate_o <= flushing_reg;
        cache_line_o       <= walk_reg;
        if (flushing_reg) begin
            walk_reg <= walk_reg + 1'b1;
            if (flush_fin) begin
                flushing_reg <= 1'b0;
            end
        end else if (cfg_done_reg && rise[`CBS_IN_PURGE]) begin
            flushing_reg <= 1'b1;
            walk_reg     <= {LINE_W{1'b0}};
        end
    end
end

// ****************************************
// interrupts
// ****************************************
wire irq_src  = ctl_dis_reg & filt_reg[`CBS_IN_LINT0];
wire nmi_rise = ctl_dis_reg & rise[`CBS_IN_LINT1];
wire nmi_ret  = handler_return_i & in_nmi_reg;
assign irq_take = irq_src & ctrl_reg[`CBS_CTRL_IF] & instr_done_i & ~irq_wait_reg;

always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        local_irq_o  <= 2'h0;
        irq_wait_reg <= 1'b0;
        irq_take_o   <= 1'b0;
        nmi_take_o   <= 1'b0;
        in_nmi_reg   <= 1'b0;
        nmi_pend_reg <= 1'b0;
        irq_vector_o <= 8'h00;
    end else begin
        local_irq_o <= ctl_dis_reg ? 2'h0 : filt_reg[`CBS_IN_LINT1:`CBS_IN_LINT0];
        irq_take_o  <= irq_take;
        nmi_take_o  <= 1'b0;
        // one acknowledge per assertion; re-armed once the pin drops
        irq_wait_reg <= irq_take | (irq_wait_reg & irq_src);
        if (nmi_ret) begin
            if (nmi_pend_reg || nmi_rise) begin
                nmi_take_o   <= 1'b1;
                irq_vector_o <= `CBS_NMI_VECTOR;
                nmi_pend_reg <= nmi_pend_reg & nmi_rise;
            end else begin
                in_nmi_reg <= 1'b0;
            end
        end else if (nmi_rise) begin
            if (in_nmi_reg) begin
                nmi_pend_reg <= 1'b1;
            end else begin
                in_nmi_reg   <= 1'b1;
                nmi_take_o   <= 1'b1;
                irq_vector_o <= `CBS_NMI_VECTOR;
            end
        end
    end
end

// ****************************************
// faults, numeric errors, warm restart, snoop stall
// ****************************************
wire warm_rise = cfg_done_reg & rise[`CBS_IN_WARM];
wire ovrd_eff  = filt_reg[`CBS_IN_OVRD] & ~ctrl_reg[`CBS_CTRL_NE];

always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
        ifault_reg           <= 1'b0;
        internal_fault_out_o <= 1'b0;
        fp_err_reg           <= 1'b0;
        fpu_fault_out_o      <= 1'b0;
        fp_stall_o           <= 1'b0;
        int_reset_o          <= 1'b0;
        exec_start_o         <= 1'b0;
        reset_vector_o       <= 32'h0;
        snoop_match_o        <= 1'b0;
        snoop_dirty_match_o  <= 1'b0;
    end else begin
        ifault_reg <= internal_error_i |
                      (ifault_reg & ~(ctrl_reg[`CBS_CTRL_IFCLR] | bus_reinit_i | warm_rise));
        internal_fault_out_o <= ifault_reg;
        fp_err_reg      <= fp_error_i | ctrl_reg[`CBS_CTRL_FPSET] | (fp_err_reg & ~ctrl_reg[`CBS_CTRL_FPCLR]);
        fpu_fault_out_o <= fp_err_reg & ~ctrl_reg[`CBS_CTRL_FPMSK];
        fp_stall_o      <= fp_err_reg & fp_instr_i & ~ovrd_eff;
        // only integer state restarts; caches, fp state and snooping carry on
        int_reset_o     <= warm_rise;
        exec_start_o    <= warm_rise;
        if (warm_rise) begin
            reset_vector_o <= RESET_VECTOR;
        end
        snoop_match_o       <= ctrl_reg[`CBS_CTRL_SNOOP];
        snoop_dirty_match_o <= ctrl_reg[`CBS_CTRL_SNOOP];
    end
end

endmodule

// ### design/cbs_defines.vh
// constants for the processor bus and sideband block
`ifndef CBS_DEFINES_VH
`define CBS_DEFINES_VH
// apb byte offsets
`define CBS_REG_CTRL    8'h00
`define CBS_REG_CMD     8'h04
`define CBS_REG_ADDR    8'h08
`define CBS_REG_WDLO    8'h0C
`define CBS_REG_WDHI    8'h10
`define CBS_REG_STATUS  8'h14
`define CBS_REG_RDLO    8'h18
`define CBS_REG_RDHI    8'h1C
`define CBS_REG_CONFIG  8'h20
// ctrl fields
`define CBS_CTRL_IF     0
`define CBS_CTRL_NE     1
`define CBS_CTRL_FPMSK  2
`define CBS_CTRL_SNOOP  3
`define CBS_CTRL_FPSET  4
`define CBS_CTRL_FPCLR  5
`define CBS_CTRL_IFCLR  6
`define CBS_CTRL_ECCCLR 7
`define CBS_CTRL_RST    8'h00
// cmd fields
`define CBS_CMD_LOCK    8
`define CBS_CMD_LAST    9
`define CBS_CMD_DATA    10
// async input slots
`define CBS_IN_PURGE    0
`define CBS_IN_WARM     1
`define CBS_IN_LINT0    2
`define CBS_IN_LINT1    3
`define CBS_IN_OVRD     4
`define CBS_IN_SUPPLY   5
`define CBS_IN_IRQD0    6
`define CBS_IN_ECCSTRAP 7
// bus commands issued by hardware, and the nmi vector
`define CBS_CMD_IRQ_ACK   5'h08
`define CBS_CMD_FLUSH_ACK 5'h09
`define CBS_CMD_SHUTDOWN  5'h0A
`define CBS_NMI_VECTOR    8'h02
// states
`define CBS_ST_IDLE     2'h0
`define CBS_ST_REQ      2'h1
`define CBS_ST_DATA     2'h2
`endif

// ### tb/cbs_sideband_properties.sv
// assertion checker for the sideband block
`timescale 1ns/100ps
`include "cbs_defines.vh"
module cbs_sideband_properties #(parameter RESET_VECTOR = 32'hFFFFFFF0) (
    input wire        ref_clk_i, rst_n_i, addr_strobe_o, data_oe_o, data_valid_strobe_o,
    input wire        atomic_seq_o, snoop_match_o, snoop_dirty_match_o, purge_req_i,
    input wire        cache_alloc_en_o, irq_take_o, nmi_take_o, exec_start_o,
    input wire [4:0]  req_cmd_o,
    input wire [63:0] data_o,
    input wire [7:0]  data_ecc_lines_o, irq_vector_o,
    input wire [31:0] reset_vector_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ack;
        addr_strobe_o && req_cmd_o == `CBS_CMD_IRQ_ACK;
    endsequence
    a_cmd_strobe: assert property ((req_cmd_o != 5'h00) == addr_strobe_o)
        else $error("command without strobe");
    a_beat_ecc: assert property (data_valid_strobe_o |-> data_oe_o &&
        data_ecc_lines_o[0] == ^data_o[7:0] && data_ecc_lines_o[7] == ^data_o[63:56])
        else $error("bad beat");
    a_alloc_off: assert property (purge_req_i [*6] |-> !cache_alloc_en_o)
        else $error("alloc during purge");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i [*2] |->
        !addr_strobe_o && !data_oe_o && !atomic_seq_o) else $error("bus busy in reset");
    a_snoop_pair: assert property (snoop_match_o == snoop_dirty_match_o)
        else $error("snoop lines apart");
    a_nmi_vec: assert property (nmi_take_o |-> irq_vector_o == `CBS_NMI_VECTOR && !irq_take_o)
        else $error("nmi vector");
    a_irq_ack: assert property (irq_take_o |-> ##[1:60] s_ack)
        else $error("no irq ack");
    a_warm_vec: assert property (exec_start_o |-> reset_vector_o == RESET_VECTOR)
        else $error("reset vector");
endmodule
bind cbs_sideband cbs_sideband_properties #(.RESET_VECTOR(RESET_VECTOR)) i_chk (.*);

// ### tb/cbs_chipset_model.sv
// chipset model: target ready, inbound beats, priority requests
`timescale 1ns/100ps
module cbs_chipset_model (
    input wire          ref_clk_i, rst_n_i, addr_strobe_o, atomic_seq_o,
    output logic        target_ready_i = 1'b0, data_valid_strobe_i = 1'b0,
    output logic        priority_agent_request_i = 1'b0,
    output logic [63:0] data_i = 64'h0,
    output logic [7:0]  data_ecc_lines_i = 8'h0
);
    logic [15:0] r = 16'h5A3C;
    always @(posedge ref_clk_i) begin
        r <= {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
        // random stalls give prompt and slow targets
        target_ready_i <= rst_n_i && r[0] | r[1];
        priority_agent_request_i <= rst_n_i && !atomic_seq_o && r[2] & r[3] & r[4];
        data_valid_strobe_i <= rst_n_i && r[5] & r[6];
        if (r[5] & r[6]) begin
            data_i <= {4{r}};
            data_ecc_lines_i <= {4{^r[15:8], ^r[7:0]}};
        end else begin
            // released lines never hold the last value
            data_i <= ~data_i;
            data_ecc_lines_i <= ~data_ecc_lines_i;
        end
    end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the sideband block
`timescale 1ns/100ps
`include "cbs_defines.vh"
module tb_top;
    logic ref_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, purge_req_i = 1;
    logic warm_restart_i = 1, supply_stable_in_i = 0, irq_bus_data0_i = 0, ecc_strap_i = 1;
    logic numeric_error_override_i = 0, fp_error_i = 0, fp_instr_i = 0, internal_error_i = 0;
    logic instr_done_i = 1, handler_return_i = 0, cache_line_dirty_i = 1, bus_reinit_i = 0;
    logic snoop_match_i = 0, snoop_dirty_match_i = 0, err;
    logic [1:0] local_irq_pins_i = 0, local_irq_o, cache_line_o;
    logic [7:0] paddr_i = 0, data_ecc_lines_o, data_ecc_lines_i, irq_vector_o;
    logic [31:0] pwdata_i = 0, prdata_o, reset_vector_o, rd;
    logic [32:0] addr_o;
    logic [63:0] data_o, data_i, w;
    logic [4:0] req_cmd_o;
    logic pready_o, pslverr_o, addr_strobe_o, data_oe_o, data_valid_strobe_o, atomic_seq_o;
    logic snoop_match_o, snoop_dirty_match_o, target_ready_i, data_valid_strobe_i, priority_agent_request_i;
    logic fpu_fault_out_o, internal_fault_out_o, fp_stall_o, cache_writeback_o, cache_invalidate_o;
    logic cache_alloc_en_o, int_reset_o, exec_start_o, bist_run_o, irq_take_o, nmi_take_o;
    logic [15:0] seed = 16'hA016;
    int n_fail = 0, samples_checked = 0, cyc = 0, c, n_cmd[32], n_bist = 0, n_nmi = 0, n_wb = 0, n_rst = 0;
    int n_ack0;
    cbs_sideband #(.CACHE_LINES(4), .LINE_W(2)) i_dut (.*);
    cbs_chipset_model i_cs (.*);
    initial forever #50 ref_clk_i = ~ref_clk_i;
    function automatic [15:0] lfsr(input [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic [7:0] ecc(input [63:0] d);
        for (int k = 0; k < 8; k++) ecc[k] = ^d[8*k+:8];
    endfunction
    task chk(input string nm, input logic [63:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task clks(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= ad;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task give_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (rst_n_i) begin
            if (addr_strobe_o) n_cmd[req_cmd_o]++;
            n_bist += bist_run_o;
            n_nmi += nmi_take_o;
            n_wb += cache_writeback_o;
            n_rst += int_reset_o;
        end
        if (cyc == 20000) begin
            n_fail++;
            give_verdict;
        end
    end
    initial begin
        clks(3);
        supply_stable_in_i <= 1'b1;
        clks(9);
        rst_n_i <= 1'b1;
        clks(1);
        purge_req_i <= 1'b0;
        warm_restart_i <= 1'b0;
        clks(40);
        apb(1'b0, `CBS_REG_CONFIG, 32'h0);
        chk("config", 4'hF, rd[3:0]);
        chk("bist", 1, n_bist);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 33'h100000000, {err, rd});
        for (int i = 1; i < 5; i++) begin
            seed = lfsr(seed);
            w = {seed, ~seed, lfsr(seed), seed ^ 16'h5A5A};
            apb(1'b1, `CBS_REG_WDLO, w[31:0]);
            apb(1'b1, `CBS_REG_WDHI, w[63:32]);
            apb(1'b1, `CBS_REG_ADDR, w[31:0]);
            apb(1'b1, `CBS_REG_CMD, 32'h400 | i);
            @(posedge ref_clk_i iff addr_strobe_o);
            chk("cmd", i, req_cmd_o);
            chk("addr", w[31:0], addr_o);
            @(posedge ref_clk_i iff data_valid_strobe_o);
            chk("beat", w, data_o);
            chk("ecc", ecc(w), data_ecc_lines_o);
        end
        apb(1'b1, `CBS_REG_CMD, 32'h105);
        @(posedge ref_clk_i iff addr_strobe_o);
        clks(3);
        chk("atomic held", 1, atomic_seq_o);
        apb(1'b1, `CBS_REG_CMD, 32'h306);
        @(posedge ref_clk_i iff addr_strobe_o);
        clks(4);
        chk("atomic end", 0, atomic_seq_o);
        apb(1'b1, `CBS_REG_CTRL, 32'h8);
        clks(2);
        chk("snoop", 2'b11, {snoop_match_o, snoop_dirty_match_o});
        snoop_match_i <= 1'b1;
        snoop_dirty_match_i <= 1'b1;
        apb(1'b0, `CBS_REG_STATUS, 32'h0);
        chk("status", 3'b110, {rd[9:8], rd[5]});
        snoop_match_i <= 1'b0;
        snoop_dirty_match_i <= 1'b0;
        apb(1'b1, `CBS_REG_CTRL, 32'h1);
        c = n_cmd[8];
        local_irq_pins_i <= 2'b01;
        @(posedge ref_clk_i iff addr_strobe_o && req_cmd_o == `CBS_CMD_IRQ_ACK);
        local_irq_pins_i <= 2'b00;
        clks(10);
        chk("one ack", c + 1, n_cmd[8]);
        chk("lint out", 0, local_irq_o);
        c = n_nmi;
        n_ack0 = n_cmd[8];
        local_irq_pins_i <= 2'b10;
        clks(1);
        local_irq_pins_i <= 2'b00;
        clks(6);
        chk("glitch", c, n_nmi);
        for (int j = 0; j < 3; j++) begin
            local_irq_pins_i <= 2'b10;
            clks(4);
            local_irq_pins_i <= 2'b00;
            clks(4);
        end
        chk("nmi held", c + 1, n_nmi);
        for (int j = 2; j < 4; j++) begin
            handler_return_i <= 1'b1;
            clks(1);
            handler_return_i <= 1'b0;
            clks(4);
            chk("nmi pend", c + 2, n_nmi);
        end
        chk("no nmi ack", n_ack0, n_cmd[8]);
        c = n_cmd[9];
        rd = n_wb;
        purge_req_i <= 1'b1;
        @(posedge ref_clk_i iff addr_strobe_o && req_cmd_o == `CBS_CMD_FLUSH_ACK);
        clks(1);
        chk("flush ack", c + 1, n_cmd[9]);
        chk("writebacks", rd + 4, n_wb);
        chk("alloc off", 0, cache_alloc_en_o);
        purge_req_i <= 1'b0;
        fp_instr_i <= 1'b1;
        numeric_error_override_i <= 1'b1;
        fp_error_i <= 1'b1;
        clks(1);
        fp_error_i <= 1'b0;
        clks(6);
        chk("alloc on", 1, cache_alloc_en_o);
        chk("fp fault", 1, fpu_fault_out_o);
        chk("override", 0, fp_stall_o);
        apb(1'b1, `CBS_REG_CTRL, 32'h2);
        clks(2);
        chk("ne stall", 1, fp_stall_o);
        numeric_error_override_i <= 1'b0;
        apb(1'b1, `CBS_REG_CTRL, 32'h0);
        clks(6);
        chk("freeze", 1, fp_stall_o);
        c = n_cmd[10];
        internal_error_i <= 1'b1;
        clks(1);
        internal_error_i <= 1'b0;
        clks(20);
        chk("fault held", 1, internal_fault_out_o);
        chk("shutdown", c + 1, n_cmd[10]);
        c = n_rst;
        warm_restart_i <= 1'b1;
        clks(8);
        chk("warm clears", 0, internal_fault_out_o);
        chk("int reset", c + 1, n_rst);
        irq_bus_data0_i <= 1'b1;
        rst_n_i <= 1'b0;
        clks(4);
        rst_n_i <= 1'b1;
        clks(8);
        c = n_nmi;
        local_irq_pins_i <= 2'b11;
        clks(6);
        chk("lint on", 2'b11, local_irq_o);
        chk("lint no nmi", c, n_nmi);
        give_verdict;
    end
endmodule
